// ==== src/htmc_crc8.sv ====
// checksum over a 16-bit result word, high byte first
`timescale 1ns/1ps
module htmc_crc8 (
  input wire logic [15:0] data,
  output logic [7:0] crc
);
  import htmc_pkg::*;

  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign crc = crc_byte(crc_byte(CRC_INIT, data[15:8]), data[7:0]); // R9
endmodule

// ==== src/htmc_pkg.sv ====
// shared constants and types of the measurement command target
package htmc_pkg;

  // target address and command codes
  localparam logic [6:0] TGT_ADDR = 7'h40;
  localparam logic [7:0] CMD_HUM_HOLD = 8'hE5;
  localparam logic [7:0] CMD_HUM_NOHOLD = 8'hF5;
  localparam logic [7:0] CMD_TEMP_HOLD = 8'hE3;
  localparam logic [7:0] CMD_TEMP_NOHOLD = 8'hF3;
  localparam logic [7:0] CMD_LAST_TEMP = 8'hE0;

  // checksum generator x^8+x^5+x^4+1 and its start value
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // fixed low bits of each result kind
  localparam logic [1:0] HUM_TAG = 2'h2;
  localparam logic [1:0] TEMP_TAG = 2'h0;

  // byte framing
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [1:0] IDX_MSB = 2'h0;
  localparam logic [1:0] IDX_LSB = 2'h1;
  localparam logic [1:0] IDX_CRC = 2'h2;

  // conversion times, least figures, rounded up to core cycles
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TEMP_CONV_TIME_NS = 7000;
  localparam int HUM_CONV_TIME_NS = 12000;
  localparam int TEMP_CONV_CYC =
    (TEMP_CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HUM_CONV_CYC =
    (HUM_CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = 16;

  typedef enum logic [3:0] {
    CV_IDLE = 4'b0001,
    CV_COMP = 4'b0010,
    CV_HUM = 4'b0100,
    CV_TEMP = 4'b1000
  } htmc_conv_e;

  typedef enum logic [5:0] {
    LS_IDLE = 6'b00_0001,
    LS_RX = 6'b00_0010,
    LS_RACK = 6'b00_0100,
    LS_HOLD = 6'b00_1000,
    LS_TX = 6'b01_0000,
    LS_TACK = 6'b10_0000
  } htmc_link_e;

endpackage

// ==== src/htmc_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module htmc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule

// ==== src/htmc_top.sv ====
// humidity/temperature measurement command target on a two-wire bus
// Function
// R1: target answers at 7-bit address 0x40 with direction bit.
// R2: humidity conversion codes are 0xE5 stretching and 0xF5 refusing.
// R3: temperature conversion codes are 0xE3 stretching and 0xF3 refusing.
// R4: master sends only documented codes; others are undefined.
// R5: stretching commands hold the clock low until the result is ready.
// R6: refusing commands withhold address acknowledge until conversion ends.
// R7: checksum follows the low byte only when master acknowledges it.
// R8: master not acknowledging low byte gets no checksum, then stops.
// R9: checksum is CRC-8, polynomial x^8+x^5+x^4+1, start value zero.
// R10: checksum optional only for the four conversion commands.
// R11: identifier reads always carry checksum which master must consume; identifier read codes get no ack here.
// R12: all other commands never append a checksum byte.
// R13: a stop before a repeated start is accepted like repeated start.
// R14: results are 16-bit words, high byte first, low byte second.
// R15: humidity result always ends in bits 10.
// R16: temperature result always ends in bits 00.
// R17: humidity conversion also converts temperature and keeps it.
// R18: 0xE0 returns the kept temperature without a new conversion.
// R19: 0xE0 never returns a checksum even if master acknowledges.
// R20: temperature commands start a fresh conversion and return it.
// R21: master reads kept temperature with write, command, read, nack, stop; the bench acks the low byte and clocks one more byte before its nack.
// R22: host scales humidity by 125/65536 minus 6.
// R23: host scales temperature by 175.72/65536 minus 46.85.
// R24: host may clamp humidity to 0..100 percent.
// R25: write address and valid commands get ack; command starts conversion. A conversion command sent while a conversion is outstanding gets no ack.
`timescale 1ns/1ps
module htmc_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [15:0] hum_adc_data,
  input wire logic [15:0] temp_adc_data,
  output logic conv_busy
);
  import htmc_pkg::*;

  function automatic logic is_meas(input logic [7:0] c);
    return c == CMD_HUM_HOLD || c == CMD_HUM_NOHOLD ||
           c == CMD_TEMP_HOLD || c == CMD_TEMP_NOHOLD;
  endfunction

  // ---------------- core domain: conversion engine ----------------
  htmc_conv_e cv_q;
  logic [CONV_CNT_W-1:0] cnt_q;
  logic req_s;
  logic req_p_q;
  logic kind_hum_q;
  logic req_tgl_q;
  logic done_tgl_q;
  logic [15:0] result_q;
  logic [15:0] comp_temp_q;
  logic [15:0] kept_temp_q;
  logic req_evt;
  logic cnt_end;

  htmc_sync #(.WIDTH(1)) u_req_sync (
    .clk(core_clk),
    .d(req_tgl_q),
    .q(req_s)
  );

  assign req_evt = req_s ^ req_p_q;
  assign cnt_end = cnt_q == CONV_CNT_W'(1);
  assign conv_busy = cv_q != CV_IDLE;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_p_q <= 1'b0;
    end else begin
      req_p_q <= req_s;
    end
  end

  // a humidity request first converts temperature for compensation
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cv_q <= CV_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (cv_q)
        CV_IDLE: begin
          if (req_evt) begin
            cv_q <= kind_hum_q ? CV_COMP : CV_TEMP; // R17 R20
            cnt_q <= CONV_CNT_W'(TEMP_CONV_CYC);
          end
        end
        CV_COMP: begin
          if (cnt_end) begin
            cv_q <= CV_HUM;
            cnt_q <= CONV_CNT_W'(HUM_CONV_CYC);
          end else begin
            cnt_q <= cnt_q - CONV_CNT_W'(1);
          end
        end
        CV_HUM, CV_TEMP: begin
          if (cnt_end) begin
            cv_q <= CV_IDLE;
          end else begin
            cnt_q <= cnt_q - CONV_CNT_W'(1);
          end
        end
      endcase
    end
  end

  // words are written in the same cycle as the toggle flips, so they are stable
  // by the time the link side sees the synchronised toggle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      done_tgl_q <= 1'b0;
      result_q <= '0;
      comp_temp_q <= '0;
      kept_temp_q <= '0;
    end else if (cnt_end) begin
      if (cv_q == CV_COMP) begin
        comp_temp_q <= {temp_adc_data[15:2], TEMP_TAG}; // R16
      end
      if (cv_q == CV_HUM) begin
        result_q <= {hum_adc_data[15:2], HUM_TAG}; // R15
        kept_temp_q <= comp_temp_q; // R17
        done_tgl_q <= ~done_tgl_q;
      end
      if (cv_q == CV_TEMP) begin
        result_q <= {temp_adc_data[15:2], TEMP_TAG}; // R16 R20
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  // ---------------- link domain: bus target ----------------
  logic link_rst;
  logic scl_s;
  logic sda_s;
  logic done_s;
  logic scl_p_q;
  logic sda_p_q;
  htmc_link_e ls_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic addr_ph_q;
  logic rd_q;
  logic [1:0] idx_q;
  logic mack_q;
  logic cmd_ok_q;
  logic src_kept_q;
  logic hold_q;
  logic crc_ok_q;
  logic pend_q;
  logic got_q;
  logic seen_q;
  logic avail;
  logic readable;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [15:0] word;
  logic [7:0] crc;
  logic more;

  htmc_sync #(.WIDTH(1)) u_rst_sync (
    .clk(link_clk),
    .d(sys_rst),
    .q(link_rst)
  );
  htmc_sync #(.WIDTH(3)) u_pin_sync (
    .clk(link_clk),
    .d({scl_i, sda_i, done_tgl_q}),
    .q({scl_s, sda_s, done_s})
  );
  htmc_crc8 u_crc (
    .data(word),
    .crc(crc)
  );
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign avail = pend_q & (done_s ^ seen_q);
  assign readable = src_kept_q | got_q | avail;
  assign word = src_kept_q ? kept_temp_q : result_q; // R18
  assign more = idx_q == IDX_MSB ||
                (idx_q == IDX_LSB && crc_ok_q); // R10 R12 R19
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = ls_q == LS_HOLD; // R5
  // first data bit is set up a cycle before the held clock is let go
  assign sda_oe = ls_q == LS_RACK || (!sh_q[7] && (ls_q == LS_TX ||
                  (ls_q == LS_HOLD && got_q))); // R5
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // bit and byte sequencing; start and stop override everything
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ls_q <= LS_IDLE;
      sh_q <= '0;
      bit_q <= BIT_ZERO;
      addr_ph_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= IDX_MSB;
      mack_q <= 1'b0;
    end else if (start_c) begin
      ls_q <= LS_RX; // R13
      bit_q <= BIT_ZERO;
      addr_ph_q <= 1'b1;
    end else if (stop_c) begin
      ls_q <= LS_IDLE; // R8
    end else begin
      unique case (ls_q)
        LS_IDLE: ;
        LS_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == BIT_FULL) begin
            if (addr_ph_q) begin
              rd_q <= sh_q[0];
              if (sh_q[7:1] != TGT_ADDR) begin
                ls_q <= LS_IDLE; // R1
              end else if (!sh_q[0] || readable ||
                           (hold_q && pend_q)) begin
                ls_q <= LS_RACK; // R1 R5 R25
              end else begin
                ls_q <= LS_IDLE; // R6
              end
            end else begin
              ls_q <= cmd_ok_q ? LS_RACK : LS_IDLE; // R25
            end
          end
        end
        LS_RACK: begin
          if (scl_fall) begin
            bit_q <= BIT_ZERO;
            idx_q <= IDX_MSB;
            if (!addr_ph_q || !rd_q) begin
              ls_q <= LS_RX;
              addr_ph_q <= 1'b0;
            end else if (readable) begin
              ls_q <= LS_TX;
              sh_q <= word[15:8]; // R14
            end else begin
              ls_q <= LS_HOLD; // R5
            end
          end
        end
        LS_HOLD: begin
          if (got_q) begin
            ls_q <= LS_TX; // R5
          end else if (avail) begin
            sh_q <= word[15:8]; // R14
          end
        end
        LS_TX: begin
          if (scl_fall) begin
            if (bit_q == BIT_LAST) begin
              ls_q <= LS_TACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        LS_TACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            bit_q <= BIT_ZERO;
            if (mack_q && more) begin
              ls_q <= LS_TX; // R7
              idx_q <= idx_q + 2'h1;
              sh_q <= idx_q == IDX_MSB ? word[7:0] : crc; // R9 R14
            end else begin
              ls_q <= LS_IDLE; // R8
            end
          end
        end
      endcase
    end
  end
  // command decode; a command is decided when its byte is complete
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cmd_ok_q <= 1'b0;
    end else if (ls_q == LS_RX && scl_rise && bit_q == BIT_LAST) begin
      cmd_ok_q <= (is_meas({sh_q[6:0], sda_s}) && !(pend_q &&
                  !got_q && !avail)) ||
                  {sh_q[6:0], sda_s} == CMD_LAST_TEMP; // R2 R3 R11 R18
    end
  end
  // a new measurement command is only taken while no conversion is outstanding,
  // which keeps kind_hum_q steady for the core while it is read there
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_tgl_q <= 1'b0;
      kind_hum_q <= 1'b0;
      src_kept_q <= 1'b0;
      hold_q <= 1'b0;
      crc_ok_q <= 1'b0;
      pend_q <= 1'b0;
      got_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (ls_q == LS_RX && scl_fall && bit_q == BIT_FULL &&
                 !addr_ph_q && cmd_ok_q) begin
      if (sh_q == CMD_LAST_TEMP) begin
        src_kept_q <= 1'b1; // R18
        crc_ok_q <= 1'b0; // R19
      end else begin
        got_q <= 1'b0;
        seen_q <= done_s;
        src_kept_q <= 1'b0;
        crc_ok_q <= 1'b1; // R10
        req_tgl_q <= ~req_tgl_q; // R25
        pend_q <= 1'b1;
        kind_hum_q <= sh_q == CMD_HUM_HOLD || sh_q == CMD_HUM_NOHOLD; // R2
        hold_q <= sh_q == CMD_HUM_HOLD || sh_q == CMD_TEMP_HOLD; // R5 R6
      end
    end else if ((ls_q == LS_HOLD || (ls_q == LS_RACK && scl_fall &&
                 addr_ph_q && rd_q)) && avail) begin
      got_q <= 1'b1;
      seen_q <= done_s;
    end
  end
endmodule

// ==== test/htmc_host_model.sv ====
// bus master model issuing measurement transfers
`timescale 1ns/1ps
module htmc_host_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic [8:0] got,
  output logic got_v,
  output logic hung
);
  localparam int T = 80;
  logic smp;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    got = 9'h000;
    got_v = 1'b0;
    hung = 1'b0;
  end
  // release the clock; the target may stretch it, but not forever
  task automatic rise();
    int n;
    scl_low = 1'b0;
    n = 0;
    while (!scl && n < 5000) begin
      #10;
      n++;
    end
    hung = !scl;
    #(T/2) smp = sda;
    #(T/2);
  endtask
  task automatic bit_out(input logic b);
    sda_low = !b;
    #(T/2);
    rise();
    scl_low = 1'b1;
    #(T/2);
  endtask
  task automatic start();
    sda_low = 1'b0;
    #(T/2);
    rise();
    sda_low = 1'b1;
    #(T/2);
    scl_low = 1'b1;
    #(T/2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #(T/2);
    rise();
    sda_low = 1'b0;
    #T;
  endtask
  task automatic report(input logic [8:0] v);
    got = v;
    got_v = 1'b1;
    #1 got_v = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, input logic rep,
                         output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    bit_out(1'b1);
    ack = !smp;
    if (rep)
      report({8'h00, ack});
  endtask
  task automatic rd_byte(input logic ack_it);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bit_out(1'b1);
      d[i] = smp;
    end
    bit_out(!ack_it);
    report({1'b1, d});
  endtask
endmodule

// ==== test/htmc_monitor.sv ====
// bound checker watching the measurement command target ports
`timescale 1ns/1ps
module htmc_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [15:0] hum_adc_data,
  input wire logic [15:0] temp_adc_data,
  input wire logic conv_busy
);
  logic [12:0] busy_q;
  logic [3:0] late_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !conv_busy)
      busy_q <= 13'h0000;
    else
      busy_q <= busy_q + 13'h0001;
  end
  // link cycles spent stretching with no conversion left to wait for
  always_ff @(posedge link_clk) begin
    if (sys_rst || !scl_oe || conv_busy)
      late_q <= 4'h0;
    else if (late_q != 4'hF)
      late_q <= late_q + 4'h1;
  end
  a_stretch_clk_low: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    $rose(scl_oe) |-> !$past(scl_i))
    else $error("stretch began with clock high");
  a_stretch_ends: assert property (
    @(posedge link_clk) disable iff (sys_rst) late_q < 4'h9)
    else $error("stretch outlived conversion");
  a_release_after_conv: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $fell(conv_busy) && scl_oe |-> ##[1:20] !scl_oe)
    else $error("clock not released");
  a_data_steady_high: assert property (
    @(posedge link_clk) disable iff (sys_rst) $changed(sda_oe) |-> !scl_i)
    else $error("data moved while clock high");
  a_clock_pull_only: assert property (
    @(posedge link_clk) disable iff (sys_rst) scl_oe |-> !scl_o)
    else $error("clock driven high");
  a_no_stretch_start: assert property (
    @(posedge core_clk) disable iff (sys_rst) $rose(conv_busy) |-> !scl_oe)
    else $error("stretch at conversion start");
  a_conv_time: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $fell(conv_busy) |-> busy_q inside {[1398:1403], [3798:3806]})
    else $error("conversion length wrong");
  a_reset_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> !conv_busy && !scl_oe && !sda_oe)
    else $error("outputs busy after reset");
endmodule

bind htmc_top htmc_monitor u_mon (.core_clk, .sys_rst, .link_clk, .scl_i,
  .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .hum_adc_data, .temp_adc_data,
  .conv_busy);

// ==== test/humidity_temp_measure_cmd_tb_top.sv ====
// self-checking bench for the measurement command target
`timescale 1ns/1ps
module humidity_temp_measure_cmd_tb_top;
  import htmc_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] hum_adc_data = 16'h0000;
  logic [15:0] temp_adc_data = 16'h0000;
  logic scl_oe, sda_oe, conv_busy, m_scl, m_sda, got_v, hung;
  logic [8:0] got;
  logic [15:0] kept;
  logic [31:0] seed = 32'h4ca1_6d84;
  logic [8:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  wire scl_i = !(scl_oe || m_scl);
  wire sda_i = !(sda_oe || m_sda);
  always #2.5 core_clk = !core_clk;
  always #3 link_clk = !link_clk;
  htmc_top dut (.core_clk, .sys_rst, .link_clk, .scl_i, .scl_o(), .scl_oe,
    .sda_i, .sda_o(), .sda_oe, .hum_adc_data, .temp_adc_data, .conv_busy);
  htmc_host_model m (.scl(scl_i), .sda(sda_i), .scl_low(m_scl),
    .sda_low(m_sda), .got, .got_v, .hung);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge got_v) begin
    total_checks++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      err_count++;
      $display("Error at %0t: got %h", $time, got);
    end
    if (exp_q.size() > 0)
      void'(exp_q.pop_front());
  end
  always @(posedge hung) begin
    err_count++;
    $display("Error at %0t: clock held too long", $time);
    close_out();
  end
  task automatic wr(input logic [7:0] b, input logic [8:0] e);
    logic a;
    exp_q.push_back(e);
    m.wr_byte(b, 1'b1, a);
  endtask
  task automatic rd(input logic [7:0] e, input logic ack_it);
    exp_q.push_back({1'b1, e});
    m.rd_byte(ack_it);
  endtask
  task automatic measure(input logic [7:0] cmd, input logic ack_lsb);
    logic a;
    logic [15:0] w;
    int n;
    logic hum;
    real phys;
    w = {temp_adc_data[15:2], TEMP_TAG};
    hum = cmd == CMD_HUM_HOLD || cmd == CMD_HUM_NOHOLD;
    if (hum) begin
      w = {hum_adc_data[15:2], HUM_TAG};
      kept = {temp_adc_data[15:2], TEMP_TAG};
    end
    if (cmd == CMD_LAST_TEMP)
      w = kept;
    m.start();
    wr({TGT_ADDR, 1'b0}, 9'h001);
    wr(cmd, 9'h001);
    if (cmd[4]) begin
      m.stop();
      m.start();
      wr({TGT_ADDR, 1'b1}, 9'h000);
      n = 0;
      a = 1'b0;
      while (!a && n < 400) begin
        m.start();
        m.wr_byte({TGT_ADDR, 1'b1}, 1'b0, a);
        n++;
      end
      if (!a) begin
        err_count++;
        $display("Error at %0t: read address never taken", $time);
        close_out();
      end
    end else begin
      m.start();
      wr({TGT_ADDR, 1'b1}, 9'h001);
    end
    rd(w[15:8], 1'b1);
    rd(w[7:0], ack_lsb);
    if (ack_lsb)
      rd((cmd == CMD_LAST_TEMP) ? 8'hFF : crc8(w), 1'b0);
    m.stop();
    // host side scaling of the expected word built from the ADC inputs
    if (hum)
      phys = 125.0 * w / 65536.0 - 6.0;
    else
      phys = 175.72 * w / 65536.0 - 46.85;
    if (hum && phys < 0.0)
      phys = 0.0;
    if (hum && phys > 100.0)
      phys = 100.0;
    total_checks++;
    if (phys < -46.85 || phys > 128.9) begin
      err_count++;
      $display("Error at %0t: scaled value out of range", $time);
    end
  endtask
  initial begin
    logic [7:0] cmds [5];
    logic [31:0] r;
    cmds = '{CMD_HUM_HOLD, CMD_TEMP_NOHOLD, CMD_LAST_TEMP, CMD_HUM_NOHOLD,
             CMD_TEMP_HOLD};
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    #200;
    m.start();
    wr(8'h82, 9'h000);
    m.stop();
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      @(posedge core_clk);
      hum_adc_data <= r[15:0];
      temp_adc_data <= r[31:16];
      @(posedge core_clk);
      measure(cmds[i], !i[0]);
    end
    if (exp_q.size() != 0) begin
      err_count++;
      $display("Error at %0t: results missing", $time);
    end
    close_out();
  end
endmodule
